// *** config_loader.sv ***
`timescale 1ns/1ns
// Overview of operation
// - the byte at image address 0 must equal A5 before any field loads.
// - any other signature means no image and every field keeps its default.
// - vendor and product identifiers fall back to built-in defaults.
// - flags word 2 feeds u1 timeout, resume threshold, overlap and u2 exit.
// - flags word 2 feeds duplex polarity, duplex mode and mac config.
// - flags word 2 feeds the low-power ethernet bits and link-up speedup.
// - flags word 2 feeds both timeout trims; bits 23:21 are unused.
// - flags word 3 feeds the superspeed and high-speed detach times.
// - the 64-bit gpio item feeds enable, buffer, direction and data.
// - without an image the driver supplies fields, attributes and ram.
// - the descriptor ram is 512 bytes and takes word-aligned writes only.
module config_loader (
  input wire logic sys_clk,
  input wire logic rst,
  output logic ee_rd_req,
  output logic [loader_pkg::EE_AW-1:0] ee_rd_addr,
  input wire logic ee_rd_ack,
  input wire logic [7:0] ee_rd_data,
  input wire logic soft_rst,
  input wire logic reset_inhibit,
  input wire logic drv_cfg_wr,
  input wire loader_pkg::loaded_cfg_t drv_cfg,
  input wire logic attr_wr,
  input wire logic [2:0] attr_idx,
  input wire logic [15:0] attr_data,
  input wire logic desc_wr_en,
  input wire logic [loader_pkg::DESC_BAW-1:0] desc_wr_addr,
  input wire logic [31:0] desc_wr_data,
  input wire logic [loader_pkg::DESC_WAW-1:0] desc_rd_addr,
  output logic [31:0] desc_rd_data,
  input wire logic ram_source_sel,
  output logic desc_from_ram,
  output loader_pkg::loaded_cfg_t cfg,
  output logic [15:0] vendor_id,
  output logic [15:0] product_id,
  output logic image_valid,
  output logic load_done,
  output logic [loader_pkg::ATTR_COUNT-1:0][15:0] attr_len,
  output logic order_fault
);
  import loader_pkg::*;

  load_state_t state, next_state;
  logic [1:0] item, next_item;
  logic [3:0] byte_idx, next_byte_idx;
  logic next_req;
  logic [EE_AW-1:0] next_addr;
  logic next_image_valid, next_load_done;
  loaded_cfg_t next_cfg;
  logic [15:0] next_vid, next_pid;
  logic [ATTR_COUNT-1:0][15:0] next_attr_len;
  logic attr_seen, next_attr_seen, next_order_fault, next_from_ram;
  logic byte_valid, ram_we;
  logic [MAX_BYTES*8-1:0] word;
  logic drv_touched;

  assign byte_valid = ee_rd_ack && ee_rd_req && state == st_item;
  // unaligned writes are dropped
  assign ram_we = desc_wr_en && desc_wr_addr[1:0] == 2'h0;

  byte_collector #(.NBYTES(MAX_BYTES)) u_collect (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(state == st_apply),
    .byte_valid(byte_valid),
    .byte_in(ee_rd_data),
    .word(word)
  );

  desc_ram #(.WORDS(DESC_WORDS), .AW(DESC_WAW)) u_ram (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(ram_we),
    .wr_addr(desc_wr_addr[DESC_BAW-1:2]),
    .wr_data(desc_wr_data),
    .rd_addr(desc_rd_addr),
    .rd_data(desc_rd_data)
  );

  // load sequencer
  always_comb
  begin
    next_state = state;
    next_item = item;
    next_byte_idx = byte_idx;
    next_addr = ee_rd_addr;
    next_image_valid = image_valid;
    next_load_done = load_done;
    case (state)
      st_boot:
      begin
        next_state = st_sig;
        next_addr = SIG_ADDR;
      end
      st_sig:
        if (ee_rd_ack && ee_rd_req)
        begin
          if (ee_rd_data == SIG_VALUE)
          begin
            next_state = st_item;
            next_item = ITEM_ID;
            next_byte_idx = '0;
            next_addr = item_base(ITEM_ID);
          end
          else
          begin
            next_state = st_done;
            next_image_valid = 1'b0;
            next_load_done = 1'b1;
          end
        end
      st_item:
        if (byte_valid)
        begin
          if (byte_idx == item_bytes(item) - 4'h1)
            next_state = st_apply;
          else
          begin
            next_byte_idx = byte_idx + 4'h1;
            next_addr = ee_rd_addr + 9'h001;
          end
        end
      st_apply:
        if (item == ITEM_GPIO)
        begin
          next_state = st_done;
          next_image_valid = 1'b1;
          next_load_done = 1'b1;
        end
        else
        begin
          next_state = st_item;
          next_item = item + 2'h1;
          next_byte_idx = '0;
          next_addr = item_base(item + 2'h1);
        end
      st_done:
        next_state = st_done;
      default:
        next_state = st_boot;
    endcase
    // request drops for one cycle after each answer
    next_req = (next_state == st_sig || next_state == st_item) && !ee_rd_ack;
  end

  // field updates, reserved bits are never routed
  always_comb
  begin
    next_cfg = cfg;
    next_vid = vendor_id;
    next_pid = product_id;
    if (state == st_apply)
      case (item)
        ITEM_ID:
        begin
          next_vid = word[ID_VID_LSB +: 16];
          next_pid = word[ID_PID_LSB +: 16];
        end
        ITEM_FLAGS2:
        begin
          next_cfg.usb_config_reg_1.u1_idle_timeout =
            word[F2_U1_LSB +: 8];
          next_cfg.usb_config_reg_0.resume_duration_threshold =
            word[F2_HIRD_LSB +: 5];
          next_cfg.usb_config_reg_0.lfps_overlap_check_enable =
            word[F2_OVL_BIT];
          next_cfg.usb_config_reg_0.u2_exit_signal_select =
            word[F2_U2X_BIT];
          next_cfg.mac_control_reg.auto_duplex_polarity =
            word[F2_ADP_BIT];
          next_cfg.mac_control_reg.duplex_select = word[F2_DPX_BIT];
          next_cfg.mac_control_reg.mac_config = word[F2_MAC_LSB +: 2];
          next_cfg.mac_control_reg.low_power_ethernet_enable =
            word[F2_LPE_BIT];
          next_cfg.mac_control_reg.low_power_tx_clock_stop_enable =
            word[F2_STOP_BIT];
          next_cfg.mac_control_reg.tx_idle_auto_removal_enable =
            word[F2_ARM_BIT];
          next_cfg.hardware_config_reg.low_power_link_up_speedup =
            word[F2_SPD_BIT];
          next_cfg.usb_config_reg_1.high_speed_timeout_trim =
            word[F2_HST_LSB +: 3];
          next_cfg.usb_config_reg_1.full_speed_timeout_trim =
            word[F2_FST_LSB +: 3];
        end
        ITEM_FLAGS3:
        begin
          next_cfg.usb_config_reg_2.ss_detach_time =
            word[F3_SS_LSB +: 16];
          next_cfg.usb_config_reg_2.high_speed_detach_time =
            word[F3_HS_LSB +: 16];
        end
        default:
        begin
          next_cfg.gpio_config.enable = word[GP_EN_LSB +: 8];
          next_cfg.gpio_config.buffer_type = word[GP_BUF_LSB +: 8];
          next_cfg.gpio_config.direction = word[GP_DIR_LSB +: 8];
          next_cfg.gpio_config.data = word[GP_DAT_LSB +: 8];
        end
      endcase
    else if (drv_cfg_wr)
      next_cfg = drv_cfg;
    else if (soft_rst && !reset_inhibit)
    begin
      next_cfg = CFG_DEFAULT;
      next_vid = VID_DEFAULT;
      next_pid = PID_DEFAULT;
    end
  end

  // attribute lengths and descriptor source
  always_comb
  begin
    next_attr_len = attr_len;
    next_attr_seen = attr_seen;
    next_order_fault = order_fault;
    next_from_ram = ram_source_sel;
    if (attr_wr && attr_idx < 3'(ATTR_COUNT))
    begin
      next_attr_len[attr_idx] = attr_data;
      next_attr_seen = 1'b1;
    end
    if (ram_we && !attr_seen)
      next_order_fault = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= st_boot;
      item <= ITEM_ID;
      byte_idx <= '0;
      ee_rd_req <= 1'b0;
      ee_rd_addr <= SIG_ADDR;
      image_valid <= 1'b0;
      load_done <= 1'b0;
      cfg <= CFG_DEFAULT;
      vendor_id <= VID_DEFAULT;
      product_id <= PID_DEFAULT;
      attr_len <= '0;
      attr_seen <= 1'b0;
      order_fault <= 1'b0;
      desc_from_ram <= 1'b0;
    end
    else
    begin
      state <= next_state;
      item <= next_item;
      byte_idx <= next_byte_idx;
      ee_rd_req <= next_req;
      ee_rd_addr <= next_addr;
      image_valid <= next_image_valid;
      load_done <= next_load_done;
      cfg <= next_cfg;
      vendor_id <= next_vid;
      product_id <= next_pid;
      attr_len <= next_attr_len;
      attr_seen <= next_attr_seen;
      order_fault <= next_order_fault;
      desc_from_ram <= next_from_ram;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      drv_touched <= 1'b0;
    else if (drv_cfg_wr || soft_rst)
      drv_touched <= 1'b1;
  end

  a_sig_gates_load: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_sig && ee_rd_ack && ee_rd_req && ee_rd_data == SIG_VALUE
    |=> state == st_item ##0 ee_rd_addr == ID_ADDR)
    else $error("valid signature did not start item reads");
  a_bad_sig_absent: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_sig && ee_rd_ack && ee_rd_req && ee_rd_data != SIG_VALUE
    |=> load_done && !image_valid && state == st_done)
    else $error("bad signature not treated as absent");
  a_defaults_kept: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(load_done) && !image_valid && !drv_touched
    |-> cfg == CFG_DEFAULT && vendor_id == VID_DEFAULT)
    else $error("defaults lost without image");
  a_flags2_fields: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_apply && item == ITEM_FLAGS2
    |=> cfg.usb_config_reg_1.u1_idle_timeout == $past(word[31:24])
    && cfg.mac_control_reg.mac_config == $past(word[7:6])
    && cfg.hardware_config_reg.low_power_link_up_speedup
    == $past(word[12]))
    else $error("flags word 2 fields not loaded");
  a_trim_fields: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_apply && item == ITEM_FLAGS2
    |=> cfg.usb_config_reg_1.high_speed_timeout_trim == $past(word[5:3])
    && cfg.usb_config_reg_1.full_speed_timeout_trim
    == $past(word[2:0]))
    else $error("timeout trims not loaded");
  a_detach_fields: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_apply && item == ITEM_FLAGS3
    |=> cfg.usb_config_reg_2 == $past(word[31:0]))
    else $error("detach times not loaded");
  a_gpio_fields: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_apply && item == ITEM_GPIO
    |=> cfg.gpio_config.enable == $past(word[59:52])
    && cfg.gpio_config.data == $past(word[11:4]))
    else $error("gpio defaults not loaded");
  a_other_untouched: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_apply && item == ITEM_FLAGS2
    |=> $stable(cfg.gpio_config) && $stable(cfg.usb_config_reg_2))
    else $error("flags word 2 touched unrelated fields");
  a_hold_mid_item: assert property (@(posedge sys_clk) disable iff (rst)
    state == st_item && !drv_cfg_wr && !soft_rst |=> $stable(cfg))
    else $error("fields changed before item complete");
  a_ram_aligned: assert property (@(posedge sys_clk) disable iff (rst)
    desc_wr_en && desc_wr_addr[1:0] != 2'h0 |-> !ram_we)
    else $error("unaligned descriptor write accepted");
  a_ram_source: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> desc_from_ram == $past(ram_source_sel))
    else $error("ram source not selected");
  c_valid_load: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(load_done) && image_valid);
  c_absent: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(load_done) && !image_valid);
  c_ram_write: cover property (@(posedge sys_clk) disable iff (rst)
    ram_we && attr_seen);
  c_drv_write: cover property (@(posedge sys_clk) disable iff (rst)
    drv_cfg_wr && load_done && !image_valid);
endmodule

// *** loader_pkg.sv ***
package loader_pkg;
  localparam int EE_AW = 9;
  localparam logic [7:0] SIG_VALUE = 8'hA5;
  localparam logic [EE_AW-1:0] SIG_ADDR = 9'h000;
  localparam logic [EE_AW-1:0] ID_ADDR = 9'h001;
  localparam logic [EE_AW-1:0] FLAGS2_ADDR = 9'h010;
  localparam logic [EE_AW-1:0] FLAGS3_ADDR = 9'h014;
  localparam logic [EE_AW-1:0] GPIO_ADDR = 9'h018;
  localparam logic [3:0] WORD_BYTES = 4'h4;
  localparam logic [3:0] GPIO_BYTES = 4'h8;
  localparam int MAX_BYTES = 8;
  localparam logic [1:0] ITEM_ID = 2'h0;
  localparam logic [1:0] ITEM_FLAGS2 = 2'h1;
  localparam logic [1:0] ITEM_FLAGS3 = 2'h2;
  localparam logic [1:0] ITEM_GPIO = 2'h3;
  localparam int F2_U1_LSB = 24;
  localparam int F2_HIRD_LSB = 16;
  localparam int F2_OVL_BIT = 15;
  localparam int F2_U2X_BIT = 14;
  localparam int F2_ADP_BIT = 13;
  localparam int F2_SPD_BIT = 12;
  localparam int F2_STOP_BIT = 11;
  localparam int F2_LPE_BIT = 10;
  localparam int F2_ARM_BIT = 9;
  localparam int F2_DPX_BIT = 8;
  localparam int F2_MAC_LSB = 6;
  localparam int F2_HST_LSB = 3;
  localparam int F2_FST_LSB = 0;
  localparam int F3_SS_LSB = 16;
  localparam int F3_HS_LSB = 0;
  localparam int GP_EN_LSB = 52;
  localparam int GP_BUF_LSB = 36;
  localparam int GP_DIR_LSB = 20;
  localparam int GP_DAT_LSB = 4;
  localparam int ID_VID_LSB = 0;
  localparam int ID_PID_LSB = 16;
  localparam int DESC_RAM_BYTES = 512;
  localparam int DESC_WORDS = DESC_RAM_BYTES / 4;
  localparam int DESC_BAW = $clog2(DESC_RAM_BYTES);
  localparam int DESC_WAW = $clog2(DESC_WORDS);
  localparam int ATTR_COUNT = 7;
  // arbitrary neutral identifiers
  localparam logic [15:0] VID_DEFAULT = 16'h1234;
  localparam logic [15:0] PID_DEFAULT = 16'h5678;

  typedef struct packed {
    logic [4:0] resume_duration_threshold;
    logic lfps_overlap_check_enable;
    logic u2_exit_signal_select;
  } usb_config_reg_0_t;
  typedef struct packed {
    logic [7:0] u1_idle_timeout;
    logic [2:0] high_speed_timeout_trim;
    logic [2:0] full_speed_timeout_trim;
  } usb_config_reg_1_t;
  typedef struct packed {
    logic [15:0] ss_detach_time;
    logic [15:0] high_speed_detach_time;
  } usb_config_reg_2_t;
  typedef struct packed {
    logic auto_duplex_polarity;
    logic low_power_ethernet_enable;
    logic low_power_tx_clock_stop_enable;
    logic tx_idle_auto_removal_enable;
    logic duplex_select;
    logic [1:0] mac_config;
  } mac_ctl_t;
  typedef struct packed {
    logic low_power_link_up_speedup;
  } hardware_config_reg_t;
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] buffer_type;
    logic [7:0] direction;
    logic [7:0] data;
  } gpio_cfg_t;
  typedef struct packed {
    usb_config_reg_0_t usb_config_reg_0;
    usb_config_reg_1_t usb_config_reg_1;
    usb_config_reg_2_t usb_config_reg_2;
    mac_ctl_t mac_control_reg;
    hardware_config_reg_t hardware_config_reg;
    gpio_cfg_t gpio_config;
  } loaded_cfg_t;
  localparam loaded_cfg_t CFG_DEFAULT = '0;

  typedef enum logic [2:0] {
    st_boot = 3'h0,
    st_sig = 3'h1,
    st_item = 3'h3,
    st_apply = 3'h2,
    st_done = 3'h6
  } load_state_t;

  function automatic logic [EE_AW-1:0] item_base(input logic [1:0] idx);
    case (idx)
      ITEM_ID: item_base = ID_ADDR;
      ITEM_FLAGS2: item_base = FLAGS2_ADDR;
      ITEM_FLAGS3: item_base = FLAGS3_ADDR;
      default: item_base = GPIO_ADDR;
    endcase
  endfunction

  function automatic logic [3:0] item_bytes(input logic [1:0] idx);
    item_bytes = (idx == ITEM_GPIO) ? GPIO_BYTES : WORD_BYTES;
  endfunction
endpackage

// *** byte_collector.sv ***
`timescale 1ns/1ns
module byte_collector #(
  parameter int NBYTES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  output logic [NBYTES*8-1:0] word
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic [NBYTES*8-1:0] next_word;

  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (byte_valid)
      next_count = count + 4'h1;
  end

  // first byte lands in the lowest lane
  genvar i;
  generate
    for (i = 0; i < NBYTES; i++)
    begin : g_lane
      always_comb
      begin
        next_word[i*8 +: 8] = word[i*8 +: 8];
        if (clear)
          next_word[i*8 +: 8] = 8'h00;
        else if (byte_valid && count == 4'(i))
          next_word[i*8 +: 8] = byte_in;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count <= '0;
      word <= '0;
    end
    else
    begin
      count <= next_count;
      word <= next_word;
    end
  end
endmodule

// *** desc_ram.sv ***
`timescale 1ns/1ns
module desc_ram #(
  parameter int WORDS = 128,
  parameter int AW = 7
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [WORDS];
  logic [31:0] next_rd_data;

  always_comb
  begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_data <= '0;
    else
      rd_data <= next_rd_data;
  end
endmodule

// *** eeprom_model.sv ***
`timescale 1ns/1ns
module eeprom_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ee_rd_req,
  input wire logic [loader_pkg::EE_AW-1:0] ee_rd_addr,
  input wire logic [3:0] dly,
  output logic ee_rd_ack,
  output logic [7:0] ee_rd_data
);
  import loader_pkg::*;
  logic [7:0] mem [2**EE_AW];
  logic [3:0] cnt;
  // ack is a one-cycle pulse after dly waits; data toggles when not answering
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ee_rd_ack <= 1'b0;
      cnt <= 4'h0;
      ee_rd_data <= 8'h00;
    end
    else if (ee_rd_req && !ee_rd_ack && cnt >= dly)
    begin
      ee_rd_ack <= 1'b1;
      ee_rd_data <= mem[ee_rd_addr];
    end
    else
    begin
      ee_rd_ack <= 1'b0;
      cnt <= (ee_rd_req && !ee_rd_ack) ? cnt + 4'h1 : 4'h0;
      ee_rd_data <= ~ee_rd_data;
    end
  end
endmodule

// *** test_config_loader.sv ***
`timescale 1ns/1ns
module test_config_loader;
  import loader_pkg::*;
  logic sys_clk, rst, soft_rst, reset_inhibit, drv_cfg_wr, attr_wr;
  logic ee_rd_req, ee_rd_ack, desc_wr_en, ram_source_sel, desc_from_ram;
  logic image_valid, load_done, order_fault;
  logic [EE_AW-1:0] ee_rd_addr;
  logic [7:0] ee_rd_data, sig;
  logic [3:0] dly;
  logic [2:0] attr_idx;
  logic [15:0] attr_data, vendor_id, product_id, v;
  logic [DESC_BAW-1:0] desc_wr_addr;
  logic [DESC_WAW-1:0] desc_rd_addr;
  logic [31:0] desc_wr_data, desc_rd_data, f2, f3, id;
  logic [31:0] w [4];
  logic [63:0] g;
  logic [95:0] r;
  loaded_cfg_t drv_cfg, cfg, ex;
  logic [ATTR_COUNT-1:0][15:0] attr_len, lens;
  int num_errors = 0;
  int checks = 0;
  logic [127:0] exp_q [$];
  int sel_q [$];
  event sample;

  config_loader uut (.sys_clk(sys_clk), .rst(rst), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data),
    .soft_rst(soft_rst), .reset_inhibit(reset_inhibit),
    .drv_cfg_wr(drv_cfg_wr), .drv_cfg(drv_cfg), .attr_wr(attr_wr),
    .attr_idx(attr_idx), .attr_data(attr_data), .desc_wr_en(desc_wr_en),
    .desc_wr_addr(desc_wr_addr), .desc_wr_data(desc_wr_data),
    .desc_rd_addr(desc_rd_addr), .desc_rd_data(desc_rd_data),
    .ram_source_sel(ram_source_sel), .desc_from_ram(desc_from_ram),
    .cfg(cfg), .vendor_id(vendor_id), .product_id(product_id),
    .image_valid(image_valid), .load_done(load_done),
    .attr_len(attr_len), .order_fault(order_fault));
  eeprom_model eep (.sys_clk(sys_clk), .rst(rst), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .dly(dly), .ee_rd_ack(ee_rd_ack),
    .ee_rd_data(ee_rd_data));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] e);
    checks++;
    if (seen !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask

  function automatic logic [127:0] obs(input int s);
    case (s)
      0: obs = 128'(cfg);
      1: obs = 128'({vendor_id, product_id});
      2: obs = 128'({image_valid, load_done});
      3: obs = 128'(attr_len);
      4: obs = 128'(desc_rd_data);
      default: obs = 128'({desc_from_ram, order_fault});
    endcase
  endfunction

  // driver side notes the expectation, monitor compares the settled output
  task automatic note(input int s, input logic [127:0] e);
    @(negedge sys_clk);
    sel_q.push_back(s);
    exp_q.push_back(e);
    -> sample;
  endtask

  initial forever
  begin
    @(sample);
    #1;
    chk(obs(sel_q.pop_front()), exp_q.pop_front());
  end

  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic wait_done;
    for (int n = 0; n < 400 && load_done !== 1'b1; n++)
      @(posedge sys_clk);
  endtask

  task automatic put(input int a, input logic [63:0] d, input int nb);
    for (int i = 0; i < nb; i++)
      eep.mem[a + i] = d[8*i +: 8];
  endtask

  task automatic pulse_soft;
    @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial
  begin
    #100000;
    num_errors++;
    stop_test;
  end

  initial
  begin
    rst = 1'b1;
    soft_rst = 1'b0;
    reset_inhibit = 1'b0;
    drv_cfg_wr = 1'b0;
    drv_cfg = '0;
    attr_wr = 1'b0;
    attr_idx = 3'h0;
    attr_data = 16'h0000;
    desc_wr_en = 1'b0;
    desc_wr_addr = '0;
    desc_wr_data = 32'h0;
    desc_rd_addr = '0;
    ram_source_sel = 1'b0;
    dly = 4'h0;
    void'($urandom(81));
    for (int i = 0; i < 2**EE_AW; i++)
      eep.mem[i] = 8'($urandom);
    // valid image, prompt answers, random reserved bits
    f2 = $urandom;
    f3 = $urandom;
    g = {$urandom, $urandom};
    id = $urandom;
    eep.mem[SIG_ADDR] = SIG_VALUE;
    put(ID_ADDR, 64'(id), 4);
    put(FLAGS2_ADDR, 64'(f2), 4);
    put(FLAGS3_ADDR, 64'(f3), 4);
    put(GPIO_ADDR, g, 8);
    ex = {f2[20:14], f2[31:24], f2[5:0], f3, f2[13], f2[10], f2[11],
      f2[9:6], f2[12], g[59:52], g[43:36], g[27:20], g[11:4]};
    do_reset;
    for (int n = 0; n < 400; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (ee_rd_req === 1'b1 && ee_rd_addr === GPIO_ADDR + 9'h4)
        break;
    end
    note(0, 128'(ex) & ~128'hFFFFFFFF);
    wait_done;
    note(0, 128'(ex));
    note(1, 128'({id[15:0], id[31:16]}));
    note(2, 128'(2'b11));
    $display("test 1 done");
    // bad signature, slow answers
    sig = 8'($urandom);
    if (sig == SIG_VALUE)
      sig = 8'h5A;
    eep.mem[SIG_ADDR] = sig;
    dly <= 4'h5;
    do_reset;
    wait_done;
    note(2, 128'(2'b01));
    note(0, 128'(CFG_DEFAULT));
    note(1, 128'({VID_DEFAULT, PID_DEFAULT}));
    $display("test 2 done");
    // driver path: fields, attributes, ram, source, inhibit
    r = {$urandom, $urandom, $urandom};
    @(posedge sys_clk);
    drv_cfg <= r[92:0];
    drv_cfg_wr <= 1'b1;
    @(posedge sys_clk);
    drv_cfg_wr <= 1'b0;
    note(0, 128'(r[92:0]));
    lens = '0;
    for (int i = 0; i <= ATTR_COUNT; i++)
    begin
      v = (i == 5) ? 16'h0000 : 16'($urandom);
      if (i < ATTR_COUNT)
        lens[i] = v;
      @(posedge sys_clk);
      attr_wr <= 1'b1;
      attr_idx <= 3'(i);
      attr_data <= v;
    end
    @(posedge sys_clk);
    attr_wr <= 1'b0;
    note(3, 128'(lens));
    for (int k = 0; k < 4; k++)
    begin
      w[k] = $urandom;
      @(posedge sys_clk);
      desc_wr_en <= 1'b1;
      desc_wr_addr <= {7'(127 - k * 42), 2'h0};
      desc_wr_data <= w[k];
      @(posedge sys_clk);
      desc_wr_addr <= {7'(127 - k * 42), 2'h2};
      desc_wr_data <= ~w[k];
    end
    @(posedge sys_clk);
    desc_wr_en <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      desc_rd_addr <= 7'(127 - k * 42);
      @(posedge sys_clk);
      note(4, 128'(w[k]));
    end
    @(posedge sys_clk);
    ram_source_sel <= 1'b1;
    @(posedge sys_clk);
    note(5, 128'(2'b10));
    @(posedge sys_clk);
    reset_inhibit <= 1'b1;
    pulse_soft;
    note(0, 128'(r[92:0]));
    @(posedge sys_clk);
    reset_inhibit <= 1'b0;
    pulse_soft;
    note(0, 128'(CFG_DEFAULT));
    note(1, 128'({VID_DEFAULT, PID_DEFAULT}));
    $display("test 3 done");
    // ram written before any attribute
    do_reset;
    @(posedge sys_clk);
    desc_wr_en <= 1'b1;
    desc_wr_addr <= '0;
    @(posedge sys_clk);
    desc_wr_en <= 1'b0;
    @(posedge sys_clk);
    note(5, 128'(2'b11));
    $display("test 4 done");
    #5;
    stop_test;
  end
endmodule
